// File: hdl/insn_exec_pkg.sv
// constants for the three-instruction decode and execute block
package insn_exec_pkg;
   // ----------------------------------------------------------------
   // word layout
   // ----------------------------------------------------------------
   localparam int unsigned WORD_W         = 14;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned INDEX_W        = 7;
   localparam int unsigned TARGET_BIT_POS = 7;
   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [13:0] KICK_WORD      = 14'h0064;
   localparam logic [5:0]  DEC_PREFIX     = 6'h03;
   localparam logic [5:0]  XOR_PREFIX     = 6'h3a;
   // ----------------------------------------------------------------
   // reset and load values
   // ----------------------------------------------------------------
   localparam logic [7:0]  ACC_RESET      = 8'h00;
   localparam logic [7:0]  WDOG_CLEAR     = 8'h00;
   localparam logic [7:0]  PRESC_CLEAR    = 8'h00;
   localparam logic [7:0]  ONE_BYTE       = 8'h01;
   localparam logic [7:0]  ZERO_BYTE      = 8'h00;
   // ----------------------------------------------------------------
   // decoded operation
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_NONE,
      OP_KICK,
      OP_DEC,
      OP_XOR
   } op_type;
endpackage

// File: hdl/insn_decode.sv
// combinational classifier of one fetched instruction word
`timescale 1ns/1ps
`default_nettype none
module insn_decode
   import insn_exec_pkg::*;
(
   // instruction word
   input  wire logic [13:0] word_i,
   // classification
   output var  op_type      op_o
);
   // ----------------------------------------------------------------
   // pattern match
   // ----------------------------------------------------------------
   wire logic is_kick = (word_i == KICK_WORD);
   wire logic is_dec  = (word_i[13:8] == DEC_PREFIX);
   wire logic is_xor  = (word_i[13:8] == XOR_PREFIX);

   // one hot by construction, the prefixes never overlap
   always_comb begin
      if (is_kick) begin
         op_o = OP_KICK;
      end else if (is_dec) begin
         op_o = OP_DEC;
      end else if (is_xor) begin
         op_o = OP_XOR;
      end else begin
         op_o = OP_NONE;
      end
   end
endmodule
`default_nettype wire

// File: hdl/watchdog_decrement_xor_exec.sv
// decode and single-cycle execute of watchdog kick, decrement and xor immediate
//
// Contract
// - kick word clears the watchdog count to zero.
// - kick word also clears the watchdog prescaler to zero.
// - kick sets timeout_status and sleep_flag, other status untouched.
// - decrement subtracts one from the indexed register, updates zero flag.
// - target bit 0 writes accumulator, 1 writes back to the register.
// - xor immediate xors accumulator with the low instruction byte.
// - xor result goes only to accumulator; only zero flag changes.
`timescale 1ns/1ps
`default_nettype none
module watchdog_decrement_xor_exec
   import insn_exec_pkg::*;
(
   // clock and reset
   input  wire logic               mclk_i,
   input  wire logic               rst_i,
   // instruction fetch
   input  wire logic               insn_valid_i,
   input  wire logic [WORD_W-1:0]  insn_word_i,
   // data memory read port, same clock, combinational read
   input  wire logic [DATA_W-1:0]  reg_rdata_i,
   output logic [INDEX_W-1:0]      reg_index_o,
   // data memory write port
   output logic                    reg_we_o,
   output logic [INDEX_W-1:0]      reg_waddr_o,
   output logic [DATA_W-1:0]       reg_wdata_o,
   // accumulator
   output logic [DATA_W-1:0]       acc_o,
   // status bits
   output logic                    result_null_bit_o,
   output logic                    timeout_status_o,
   output logic                    sleep_flag_o,
   // watchdog
   output logic                    watchdog_clear_o,
   output logic                    prescaler_clear_o,
   output logic [DATA_W-1:0]       watchdog_count_o,
   output logic [DATA_W-1:0]       prescaler_o,
   // external events that age or trip the watchdog, and the done pulse out
   input  wire logic               prescale_tick_i,
   input  wire logic               timeout_set_i,
   input  wire logic               sleep_set_i,
   output logic                    done_o
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   op_type op;

   insn_decode u_decode (
      .word_i (insn_word_i),
      .op_o   (op)
   );

   // zero test shared by both arithmetic results
   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      return (v == ZERO_BYTE);
   endfunction

   // ----------------------------------------------------------------
   // operand fields and results
   // ----------------------------------------------------------------
   wire logic               fire      = insn_valid_i;
   wire logic               do_kick   = fire && (op == OP_KICK);
   wire logic               do_dec    = fire && (op == OP_DEC);
   wire logic               do_xor    = fire && (op == OP_XOR);
   wire logic [INDEX_W-1:0] index     = insn_word_i[INDEX_W-1:0];
   wire logic               to_reg    = insn_word_i[TARGET_BIT_POS];
   wire logic [DATA_W-1:0]  imm       = insn_word_i[DATA_W-1:0];
   wire logic [DATA_W-1:0]  dec_res   = reg_rdata_i - ONE_BYTE;
   wire logic [DATA_W-1:0]  xor_res   = acc_o ^ imm;

   // read address is steered straight from the word so the read lands this cycle
   assign reg_index_o = index;

   // ----------------------------------------------------------------
   // accumulator and zero flag
   // ----------------------------------------------------------------
   wire logic               next_acc_we = (do_dec && !to_reg) || do_xor;
   wire logic [DATA_W-1:0]  next_acc    = do_xor ? xor_res : dec_res;
   wire logic               res_zero    = is_zero(do_xor ? xor_res : dec_res);

   // single cycle update: each instruction retires on the edge it is presented
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         acc_o             <= ACC_RESET;
         result_null_bit_o <= 1'b0;
      end else begin
         if (next_acc_we) begin
            acc_o <= next_acc;
         end
         if (do_dec || do_xor) begin
            result_null_bit_o <= res_zero;
         end
      end
   end

   // ----------------------------------------------------------------
   // register write back
   // ----------------------------------------------------------------
   // registered so the memory sees a clean strobe one cycle after decode
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         reg_we_o    <= 1'b0;
         reg_waddr_o <= '0;
         reg_wdata_o <= ZERO_BYTE;
      end else begin
         reg_we_o    <= do_dec && to_reg;
         reg_waddr_o <= index;
         reg_wdata_o <= dec_res;
      end
   end

   // ----------------------------------------------------------------
   // status bits
   // ----------------------------------------------------------------
   // hardware trips clear the flags; a kick in the same cycle wins since
   // software asked for the restart last
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         timeout_status_o <= 1'b1;
         sleep_flag_o     <= 1'b1;
      end else if (do_kick) begin
         timeout_status_o <= 1'b1;
         sleep_flag_o     <= 1'b1;
      end else begin
         if (timeout_set_i) begin
            timeout_status_o <= 1'b0;
         end
         if (sleep_set_i) begin
            sleep_flag_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // watchdog count and prescaler
   // ----------------------------------------------------------------
   // the timing chain proper lives elsewhere; this copy only tracks ticks
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         watchdog_count_o  <= WDOG_CLEAR;
         prescaler_o       <= PRESC_CLEAR;
         watchdog_clear_o  <= 1'b0;
         prescaler_clear_o <= 1'b0;
         done_o            <= 1'b0;
      end else begin
         watchdog_clear_o  <= do_kick;
         prescaler_clear_o <= do_kick;
         done_o            <= do_kick || do_dec || do_xor;
         if (do_kick) begin
            watchdog_count_o <= WDOG_CLEAR;
            prescaler_o      <= PRESC_CLEAR;
         end else if (prescale_tick_i) begin
            if (prescaler_o == 8'hff) begin
               watchdog_count_o <= watchdog_count_o + ONE_BYTE;
            end
            prescaler_o <= prescaler_o + ONE_BYTE;
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/data_mem_model.sv
// behavioural data memory on the far side of the execute block
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
   input  wire logic       mclk_i,
   input  wire logic [6:0] index_i,
   output logic      [7:0] rdata_o,
   input  wire logic       we_i,
   input  wire logic [6:0] waddr_i,
   input  wire logic [7:0] wdata_i
);
   logic [7:0] mem [128];
   // each cell starts at its own index so the bench can predict reads
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
   assign rdata_o = mem[index_i];
   always @(posedge mclk_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule
`default_nettype wire

// File: sim/wdx_props.sv
// port checker for the decode and execute block
`timescale 1ns/1ps
`default_nettype none
module wdx_props
   import insn_exec_pkg::*;
(
   // watched ports, grouped by width to save room
   input wire logic        mclk_i, rst_i, insn_valid_i, reg_we_o, result_null_bit_o, done_o,
   input wire logic        timeout_status_o, sleep_flag_o, watchdog_clear_o, prescaler_clear_o,
   input wire logic        timeout_set_i, sleep_set_i,
   input wire logic [13:0] insn_word_i,
   input wire logic [6:0]  reg_waddr_o,
   input wire logic [7:0]  reg_rdata_i, reg_wdata_o, acc_o, watchdog_count_o, prescaler_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // decode of the word presented on each edge
   wire logic kick = insn_valid_i && insn_word_i == KICK_WORD;
   wire logic dec  = insn_valid_i && insn_word_i[13:8] == DEC_PREFIX;
   wire logic xr   = insn_valid_i && insn_word_i[13:8] == XOR_PREFIX;
   wire logic w7   = insn_word_i[TARGET_BIT_POS];
   sequence exec_s; kick || dec || xr; endsequence
   kick_count_a: assert property (kick |=> watchdog_count_o == WDOG_CLEAR && watchdog_clear_o)
      else $error("kick left count");
   kick_presc_a: assert property (kick |=> prescaler_o == PRESC_CLEAR && prescaler_clear_o)
      else $error("kick left prescaler");
   kick_status_a: assert property (kick |=> timeout_status_o && sleep_flag_o && $stable(result_null_bit_o))
      else $error("kick status wrong");
   dec_acc_a: assert property (dec && !w7 |=> acc_o == $past(reg_rdata_i - ONE_BYTE) && !reg_we_o)
      else $error("decrement to acc wrong");
   dec_back_a: assert property (dec && w7 |=> reg_we_o && reg_waddr_o == $past(insn_word_i[6:0])
      && reg_wdata_o == $past(reg_rdata_i - ONE_BYTE) && $stable(acc_o))
      else $error("decrement write back wrong");
   xor_acc_a: assert property (xr |=> acc_o == $past(acc_o ^ insn_word_i[7:0]))
      else $error("xor result wrong");
   xor_status_a: assert property (xr && !timeout_set_i && !sleep_set_i |=> !reg_we_o
      && $stable(timeout_status_o) && $stable(sleep_flag_o))
      else $error("xor touched status");
   null_flag_a: assert property (dec || xr |=> result_null_bit_o == ((reg_we_o ? reg_wdata_o : acc_o) == ZERO_BYTE))
      else $error("zero flag wrong");
   done_pulse_a: assert property (exec_s |=> done_o)
      else $error("done missing");
endmodule
bind watchdog_decrement_xor_exec wdx_props chk (.*);
`default_nettype wire

// File: sim/watchdog_decrement_xor_exec_tb.sv
// self-checking bench for the decode and execute block
`timescale 1ns/1ps
`default_nettype none
module watchdog_decrement_xor_exec_tb;
   import insn_exec_pkg::*;
   logic mclk_i = 1'h0, rst_i = 1'h1, insn_valid_i = 1'h0, prescale_tick_i = 1'h0, timeout_set_i = 1'h0, sleep_set_i = 1'h0;
   logic [13:0] insn_word_i = 14'h0000;
   logic [7:0]  reg_rdata_i, reg_wdata_o, acc_o, watchdog_count_o, prescaler_o;
   logic [6:0]  reg_index_o, reg_waddr_o;
   logic        reg_we_o, result_null_bit_o, timeout_status_o, sleep_flag_o, watchdog_clear_o, prescaler_clear_o, done_o;
   int          mismatches = 0, checks_done = 0, cycles = 0;
   initial forever #20 mclk_i = ~mclk_i;
   watchdog_decrement_xor_exec dut (.*);
   data_mem_model mem (.mclk_i, .index_i(reg_index_o), .rdata_o(reg_rdata_i), .we_i(reg_we_o),
      .waddr_i(reg_waddr_o), .wdata_i(reg_wdata_o));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one instruction, judged just after the edge that takes it
   task automatic exec(input logic [13:0] w);
      @(posedge mclk_i);
      insn_valid_i <= 1'h1;
      insn_word_i <= w;
      @(posedge mclk_i);
      insn_valid_i <= 1'h0;
      #1;
   endtask
   task automatic t_kick;
      @(posedge mclk_i);
      {timeout_set_i, sleep_set_i, prescale_tick_i} <= 3'h7;
      repeat (3) @(posedge mclk_i);
      {timeout_set_i, sleep_set_i, prescale_tick_i} <= 3'h0;
      exec(KICK_WORD);
      chk(watchdog_count_o, WDOG_CLEAR);
      chk({prescaler_o[6:0], prescaler_clear_o}, 8'h01);
      chk({4'h0, timeout_status_o, sleep_flag_o, result_null_bit_o, done_o}, 8'h0d);
      // a full prescaler wrap ages the count, so the next kick has a nonzero count to clear
      prescale_tick_i <= 1'h1;
      repeat (256) @(posedge mclk_i);
      prescale_tick_i <= 1'h0;
      #1;
      chk(watchdog_count_o, 8'h01);
      chk(prescaler_o, 8'h00);
      exec(KICK_WORD);
      chk(watchdog_count_o, WDOG_CLEAR);
      chk({7'h00, watchdog_clear_o}, 8'h01);
   endtask
   task automatic t_dec;
      exec({DEC_PREFIX, 8'h05});
      chk(acc_o, 8'h04);
      exec({DEC_PREFIX, 8'h01});
      chk({acc_o[6:0], result_null_bit_o}, 8'h01);
      exec({DEC_PREFIX, 8'h80});
      chk(reg_wdata_o, 8'hff);
      chk({reg_we_o, reg_waddr_o}, 8'h80);
      chk({acc_o[6:0], result_null_bit_o}, 8'h00);
      exec({DEC_PREFIX, 8'hff});
      chk(reg_wdata_o, 8'h7e);
      chk({reg_we_o, reg_waddr_o}, 8'hff);
      exec({DEC_PREFIX, 8'h00});
      chk(acc_o, 8'hfe);
   endtask
   task automatic t_xor;
      exec({XOR_PREFIX, 8'h4b});
      chk(acc_o, 8'hb5);
      exec({XOR_PREFIX, 8'haf});
      chk(acc_o, 8'h1a);
      exec({XOR_PREFIX, 8'h1a});
      chk({timeout_status_o, sleep_flag_o, reg_we_o, result_null_bit_o, acc_o[3:0]}, 8'hd0);
      exec(14'h0065);
      chk({done_o, acc_o[6:0]}, 8'h00);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard: the whole sequence needs under three hundred cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'h0;
      t_kick();
      t_dec();
      t_xor();
      summarize();
   end
endmodule
`default_nettype wire
